//--- verilog/bsc_sram_ctl.v
// Burst SRAM clock, control pin, read/write burst and echo clock logic
`timescale 1ns/1ps
`default_nettype none
`include "bsc_defs.vh"
module bsc_sram_ctl (
  input  wire                   clk,
  input  wire                   nrst,
  input  wire                   in_clk,
  input  wire                   in_clk_n,
  input  wire                   load_strobe_n,
  input  wire                   read_write_sel,
  input  wire [`BSC_ADDR_W-1:0] addr,
  input  wire [`BSC_DATA_W-1:0] dq_in,
  input  wire                   pll_disable_n,
  input  wire                   termination_range_select,
  output reg  [`BSC_DATA_W-1:0] dq_out,
  output reg                    dq_oe,
  output reg                    output_valid_flag,
  output reg                    true_echo_clock,
  output reg                    comp_echo_clock,
  output reg                    term_range_high,
  output reg                    legacy_mode,
  output reg                    ready
);
  localparam [2:0] ST_SYNC   = 3'h1;
  localparam [2:0] ST_SAMPLE = 3'h2;
  localparam [2:0] ST_RUN    = 3'h4;

  wire [`BSC_SYNC_W-1:0]  pins_raw;
  wire [`BSC_SYNC_W-1:0]  pins;
  wire                    k_s;
  wire                    kn_s;
  wire                    ld_n_s;
  wire                    rw_s;
  wire [`BSC_ADDR_W-1:0]  addr_s;
  wire [`BSC_DATA_W-1:0]  din_s;
  wire                    pll_n_s;
  wire                    term_s;

  reg                     k_prev;
  reg                     kn_prev;
  wire                    k_rise;
  wire                    kn_rise;
  wire                    half_evt;

  reg  [2:0]              state;
  reg  [2:0]              next_state;
  reg  [1:0]              init_cnt;
  wire                    run;

  reg  [2:0]              lat_half;
  wire [2:0]              lat_w0;
  reg                     next_term_range_high;
  reg                     next_legacy_mode;
  reg  [2:0]              next_lat_half;
  reg                     next_ready;
  wire                    rd_go;
  wire                    wr_go;

  reg  [`BSC_PIPE_N-1:0]  pv;
  reg  [`BSC_PIPE_N-1:0]  pw;
  reg  [`BSC_ADDR_W*`BSC_PIPE_N-1:0] pa;
  wire [`BSC_ADDR_W-1:0]  pa0;

  reg                     wr_p1;
  reg  [`BSC_ADDR_W-1:0]  wr_a1;
  reg                     wr_p2;
  reg  [`BSC_ADDR_W-1:0]  wr_a2;
  reg  [`BSC_DATA_W-1:0]  wr_d0;
  reg                     next_wr_p1;
  reg  [`BSC_ADDR_W-1:0]  next_wr_a1;
  reg                     next_wr_p2;
  reg  [`BSC_ADDR_W-1:0]  next_wr_a2;
  reg  [`BSC_DATA_W-1:0]  next_wr_d0;

  reg  [`BSC_DATA_W-1:0]  mem0 [0:`BSC_DEPTH-1];
  reg  [`BSC_DATA_W-1:0]  mem1 [0:`BSC_DEPTH-1];
  wire [`BSC_DATA_W-1:0]  rd_word;
  reg  [`BSC_DATA_W-1:0]  next_dq_out;
  reg                     next_dq_oe;
  reg                     next_output_valid_flag;
  reg                     next_true_echo_clock;
  reg                     next_comp_echo_clock;

  // All pins come from the controller's clock domain
  assign pins_raw = {in_clk, in_clk_n, load_strobe_n, read_write_sel,
                     addr, dq_in, pll_disable_n, termination_range_select};

  bsc_sync #(
    .W        (`BSC_SYNC_W)
  ) u_sync (
    .clk      (clk),
    .nrst     (nrst),
    .async_in (pins_raw),
    .sync_out (pins)
  );

  assign k_s     = pins[17];
  assign kn_s    = pins[16];
  assign ld_n_s  = pins[15];
  assign rw_s    = pins[14];
  assign addr_s  = pins[13:10];
  assign din_s   = pins[9:2];
  assign pll_n_s = pins[1];
  assign term_s  = pins[0];

  // Edge finders on the synchronised input clocks
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      k_prev  <= 1'b0;
      kn_prev <= 1'b0;
    end else begin
      k_prev  <= k_s;
      kn_prev <= kn_s;
    end
  end

  assign k_rise   = k_s & ~k_prev & run;
  assign kn_rise  = kn_s & ~kn_prev & run;
  assign half_evt = k_rise | kn_rise;

  // Power-up: wait for the synchroniser to fill, then take the straps once
  always @* begin
    case (state)
      ST_SYNC: begin
        if (init_cnt == `BSC_INIT_CYCLES) begin
          next_state = ST_SAMPLE;
        end else begin
          next_state = ST_SYNC;
        end
      end
      ST_SAMPLE: next_state = ST_RUN;
      ST_RUN:    next_state = ST_RUN;
      default:   next_state = ST_SYNC;
    endcase
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state    <= ST_SYNC;
      init_cnt <= 2'h0;
    end else begin
      state <= next_state;
      if (state == ST_SYNC) begin
        init_cnt <= init_cnt + 2'h1;
      end
    end
  end

  assign run = (state == ST_RUN);

  // Straps are read once; changing them later needs a new power-up
  always @* begin
    next_term_range_high = term_range_high;
    next_legacy_mode     = legacy_mode;
    next_lat_half        = lat_half;
    next_ready           = ready;
    if (state == ST_SAMPLE) begin
      next_term_range_high = term_s;
      next_legacy_mode     = ~pll_n_s;
      next_lat_half        = pll_n_s ? `BSC_LAT_PLL_HALF
                                     : `BSC_LAT_LEG_HALF;
      next_ready           = 1'b1;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      term_range_high <= 1'b1;
      legacy_mode     <= 1'b0;
      lat_half        <= `BSC_LAT_PLL_HALF;
      ready           <= 1'b0;
    end else begin
      term_range_high <= next_term_range_high;
      legacy_mode     <= next_legacy_mode;
      lat_half        <= next_lat_half;
      ready           <= next_ready;
    end
  end

  // Requests are only decoded at a true clock rise with load low
  assign rd_go  = k_rise & ~ld_n_s & rw_s;
  assign wr_go  = k_rise & ~ld_n_s & ~rw_s;
  // Entry 0 is shown one event after it lands, so word0 goes one slot short
  assign lat_w0 = lat_half - 3'h1;

  // Half-cycle read slot pipeline; entry 0 is the word due at this event
  genvar i;
  generate
    for (i = 0; i < `BSC_PIPE_N; i = i + 1) begin : g_pipe
      localparam [2:0] IDX = i;
      always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          pv[i]                         <= 1'b0;
          pw[i]                         <= 1'b0;
          pa[i*`BSC_ADDR_W +: `BSC_ADDR_W] <= {`BSC_ADDR_W{1'b0}};
        end else if (half_evt) begin
          if (rd_go && lat_w0 == IDX) begin
            pv[i]                         <= 1'b1;
            pw[i]                         <= 1'b0;
            pa[i*`BSC_ADDR_W +: `BSC_ADDR_W] <= addr_s;
          end else if (rd_go && lat_half == IDX) begin
            pv[i]                         <= 1'b1;
            pw[i]                         <= 1'b1;
            pa[i*`BSC_ADDR_W +: `BSC_ADDR_W] <= addr_s;
          end else if (i < `BSC_PIPE_N - 1) begin
            pv[i]                         <= pv[(i+1) % `BSC_PIPE_N];
            pw[i]                         <= pw[(i+1) % `BSC_PIPE_N];
            pa[i*`BSC_ADDR_W +: `BSC_ADDR_W] <=
              pa[((i+1) % `BSC_PIPE_N)*`BSC_ADDR_W +: `BSC_ADDR_W];
          end else begin
            pv[i]                         <= 1'b0;
            pw[i]                         <= 1'b0;
            pa[i*`BSC_ADDR_W +: `BSC_ADDR_W] <= {`BSC_ADDR_W{1'b0}};
          end
        end
      end
    end
  endgenerate

  assign pa0 = pa[`BSC_ADDR_W-1:0];

  // Write burst: first word at the next true rise, second at the complement rise
  always @* begin
    next_wr_p1 = wr_p1;
    next_wr_a1 = wr_a1;
    next_wr_p2 = wr_p2;
    next_wr_a2 = wr_a2;
    next_wr_d0 = wr_d0;
    if (k_rise) begin
      next_wr_p1 = wr_go;
      next_wr_a1 = addr_s;
      next_wr_p2 = wr_p1;
      next_wr_a2 = wr_a1;
      next_wr_d0 = din_s;
    end else if (kn_rise) begin
      // Slot is spent once the second word has gone into the array
      next_wr_p2 = 1'b0;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_p1 <= 1'b0;
      wr_a1 <= {`BSC_ADDR_W{1'b0}};
      wr_p2 <= 1'b0;
      wr_a2 <= {`BSC_ADDR_W{1'b0}};
      wr_d0 <= {`BSC_DATA_W{1'b0}};
    end else begin
      wr_p1 <= next_wr_p1;
      wr_a1 <= next_wr_a1;
      wr_p2 <= next_wr_p2;
      wr_a2 <= next_wr_a2;
      wr_d0 <= next_wr_d0;
    end
  end

  // The array itself has no reset, as a real SRAM core
  always @(posedge clk) begin
    if (kn_rise && wr_p2) begin
      mem0[wr_a2] <= wr_d0;
      mem1[wr_a2] <= din_s;
    end
  end

  // Continuous read, but a word written in this event lands at the same edge, so this event still reads the old word
  assign rd_word = pw[0] ? mem1[pa0] : mem0[pa0];

  // Echo clocks, valid flag and data all move at the same half-cycle event
  always @* begin
    next_true_echo_clock   = true_echo_clock;
    next_comp_echo_clock   = comp_echo_clock;
    next_output_valid_flag = output_valid_flag;
    next_dq_oe             = dq_oe;
    next_dq_out            = dq_out;
    if (half_evt) begin
      next_true_echo_clock   = k_rise;
      next_comp_echo_clock   = kn_rise;
      next_output_valid_flag = pv[0];
      next_dq_oe             = pv[0];
      if (pv[0]) begin
        next_dq_out = rd_word;
      end else begin
        // Parked at zero so an idle bus never repeats a stale word
        next_dq_out = {`BSC_DATA_W{1'b0}};
      end
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      true_echo_clock   <= 1'b0;
      comp_echo_clock   <= 1'b1;
      output_valid_flag <= 1'b0;
      dq_oe             <= 1'b0;
      dq_out            <= {`BSC_DATA_W{1'b0}};
    end else begin
      true_echo_clock   <= next_true_echo_clock;
      comp_echo_clock   <= next_comp_echo_clock;
      output_valid_flag <= next_output_valid_flag;
      dq_oe             <= next_dq_oe;
      dq_out            <= next_dq_out;
    end
  end
endmodule // bsc_sram_ctl
`default_nettype wire

//--- verilog/bsc_defs.vh
// Constants for the burst SRAM clock and control pin block
// What this block does
// - Load low at clock rise: select picks read/write
// - Valid flag high while read data driven
// - Valid flag changes with echo clock edges
// - True clock rise samples inputs, launches data
// - Accesses start only at true clock rise
// - Complement clock captures the second write word; launches the second read word with PLL off, the first with PLL on
// - Echo clocks free-running, follow true clock
// - PLL disable strap low turns PLL off
// - PLL off: legacy mode, clock limit 167 MHz
// - Termination range strap sampled at power-up
// - Every access bursts exactly two words
// - Read latency 2.5 cycles, or one without PLL
// - Deselected reads finish, then outputs float
`ifndef BSC_DEFS_VH
`define BSC_DEFS_VH
`define BSC_DATA_W        8
`define BSC_ADDR_W        4
`define BSC_DEPTH         16
`define BSC_PIPE_N        7
`define BSC_LAT_PLL_HALF  3'h5
`define BSC_LAT_LEG_HALF  3'h2
`define BSC_SYNC_W        18
`define BSC_INIT_CYCLES   2'h3
`define BSC_LEG_MAX_MHZ   167
`endif

//--- verilog/bsc_sync.v
// Two flip-flop synchroniser for a group of pins
`timescale 1ns/1ps
`default_nettype none
module bsc_sync #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         nrst,
  input  wire [W-1:0] async_in,
  output reg  [W-1:0] sync_out
);
  reg [W-1:0] stage1;

  // Only the second stage is read outside this module
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stage1   <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule // bsc_sync
`default_nettype wire

//--- verilog/bsc_defs_unused_note.v
// Holds no logic; the block lives in bsc_sram_ctl.v and bsc_sync.v
`timescale 1ns/1ps

//--- test/bsc_sram_ctl_checker.sv
// Port assertions for the burst SRAM control block
`timescale 1ns/1ps
`default_nettype none
`include "bsc_defs.vh"
module bsc_chk (
  input wire logic                   clk,
  input wire logic                   nrst,
  input wire logic                   in_clk,
  input wire logic                   in_clk_n,
  input wire logic                   load_strobe_n,
  input wire logic                   read_write_sel,
  input wire logic                   pll_disable_n,
  input wire logic                   termination_range_select,
  input wire logic [`BSC_DATA_W-1:0] dq_out,
  input wire logic                   dq_oe,
  input wire logic                   output_valid_flag,
  input wire logic                   true_echo_clock,
  input wire logic                   comp_echo_clock,
  input wire logic                   term_range_high,
  input wire logic                   legacy_mode,
  input wire logic                   ready
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence rd_req;
    ready && $rose(in_clk) && !load_strobe_n && read_write_sel;
  endsequence
  // Half events are four system clocks apart, so two words hold valid for eight
  sequence two_words;
    output_valid_flag [*8];
  endsequence
  valid_oe_a: assert property (output_valid_flag == dq_oe)
    else $error("valid flag and output enable differ");
  valid_edge_a: assert property ($changed(output_valid_flag) |-> $changed(true_echo_clock))
    else $error("valid flag moved without an echo edge");
  echo_pair_a: assert property (true_echo_clock != comp_echo_clock)
    else $error("echo clocks not complementary");
  idle_bus_a: assert property (!dq_oe |-> dq_out == '0)
    else $error("data driven while disabled");
  echo_rise_a: assert property (ready && $rose(in_clk) |-> ##[1:5] true_echo_clock)
    else $error("true echo did not follow input clock");
  echo_fall_a: assert property (ready && $rose(in_clk_n) |-> ##[1:5] !true_echo_clock)
    else $error("echo did not follow complement clock");
  burst_two_a: assert property ($rose(output_valid_flag) |-> two_words)
    else $error("read burst shorter than two words");
  lat_pll_a: assert property (rd_req ##0 !legacy_mode |-> ##[21:25] output_valid_flag)
    else $error("read latency wrong with pll on");
  lat_leg_a: assert property (rd_req ##0 legacy_mode |-> ##[9:13] output_valid_flag)
    else $error("read latency wrong in legacy mode");
  straps_a: assert property ($rose(ready) |-> legacy_mode == !pll_disable_n
    && term_range_high == termination_range_select) else $error("strap not taken");
endmodule // bsc_chk
bind bsc_sram_ctl bsc_chk chk_u (.*);
`default_nettype wire

//--- test/bsc_ctl_model.sv
// Memory controller model: input clocks, request pins and write data
`timescale 1ns/1ps
`default_nettype none
module bsc_ctl_model (
  input  wire logic       clk,
  input  wire logic       ready,
  output var  logic       in_clk,
  output var  logic       in_clk_n,
  output var  logic       load_strobe_n,
  output var  logic       read_write_sel,
  output var  logic [3:0] addr,
  output var  logic [7:0] dq_in
);
  // Op word: go, read, address, word0, word1
  logic [21:0] q [$];
  logic [21:0] op;
  logic [21:0] wr;
  logic [2:0]  ph;
  task push(input logic [21:0] o);
    q.push_back(o);
  endtask
  initial begin
    {in_clk, read_write_sel, addr, dq_in, op, wr, ph} = '0;
    in_clk_n = 1;
    load_strobe_n = 1;
  end
  // Period is eight system clocks, far below the legacy limit
  always @(negedge clk) begin
    if (!ready) begin
      {in_clk, op, wr, ph} = '0;
      load_strobe_n = 1;
    end else begin
      in_clk = ph < 4; // Rises at phase 0
      // Request moves half a period off the rise, so it is settled there
      if (ph == 4) begin
        wr = op;
        op = q.size() ? q.pop_front() : '0;
        load_strobe_n = !op[21];
        read_write_sel = op[20];
        addr = op[21] ? op[19:16] : ~addr;
      end
      // Unused data lines toggle so a stale value never looks valid
      if (ph == 7) dq_in = (wr[21] && !wr[20]) ? wr[15:8] : ~dq_in;
      if (ph == 3) dq_in = (wr[21] && !wr[20]) ? wr[7:0] : ~dq_in;
      ph = ph + 1;
    end
    in_clk_n = !in_clk;
  end
endmodule // bsc_ctl_model
`default_nettype wire

//--- test/tb.sv
// Self-checking bench: fill, read back with pll on then off
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk = 0, nrst = 0, pll_disable_n = 1, termination_range_select = 1, last_te = 0;
  logic        in_clk, in_clk_n, load_strobe_n, read_write_sel, dq_oe, output_valid_flag;
  logic        true_echo_clock, comp_echo_clock, term_range_high, legacy_mode, ready;
  logic [3:0]  addr;
  logic [7:0]  dq_in, dq_out;
  logic [7:0]  mem [0:31];
  logic [7:0]  exp_q [$];
  logic [31:0] rs = 32'h00012CBE;
  int          n_fail = 0, checked = 0;
  bsc_sram_ctl dut_u (.*);
  bsc_ctl_model ctl_u (.*);
  initial forever #12.5 clk = ~clk;
  function logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task close_out;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Each echo edge with valid up carries one read word
  always @(negedge clk) begin
    if (nrst && true_echo_clock !== last_te && output_valid_flag === 1'b1) begin
      chk("oe", 8'h01, {7'h00, dq_oe});
      chk("dq", exp_q.size() ? exp_q.pop_front() : 8'hXX, dq_out);
    end
    last_te = true_echo_clock;
  end
  task automatic run(input logic p);
    logic [3:0] a;
    logic [7:0] d0, d1;
    @(negedge clk);
    nrst = 0;
    pll_disable_n = p;
    d0 = 8'(xs());
    termination_range_select = d0[0];
    repeat (8) @(negedge clk);
    nrst = 1;
    repeat (6) @(negedge clk);
    chk("legacy", {7'h00, !p}, {7'h00, legacy_mode});
    chk("term", {7'h00, termination_range_select}, {7'h00, term_range_high});
    // Writes fill every address, then back-to-back reads with a few deselects
    for (int i = 0; i < 32; i++) begin
      d0 = 8'(xs());
      d1 = 8'(xs());
      a = i < 16 ? i[3:0] : d0[3:0];
      if (i < 16) begin
        mem[{a, 1'b0}] = d0;
        mem[{a, 1'b1}] = d1;
      end else if (i % 5 != 0) begin
        exp_q.push_back(mem[{a, 1'b0}]);
        exp_q.push_back(mem[{a, 1'b1}]);
      end
      ctl_u.push({i % 5 != 0 || i < 16, i >= 16, a, d0, d1});
    end
    repeat (300) @(negedge clk);
    chk("left", 8'h00, 8'(exp_q.size()));
  endtask
  initial begin
    run(1'b1);
    run(1'b0);
    close_out();
  end
  initial begin
    repeat (2000) @(posedge clk);
    n_fail++;
    close_out();
  end
endmodule // tb
`default_nettype wire
